// ---- hdl/atds_map.vh ----
`ifndef ATDS_MAP_VH
`define ATDS_MAP_VH
// Register offsets
`define ATDS_OFS_DIAG_CTL 8'h5C
`define ATDS_OFS_DIAG_STAT 8'h5E
`define ATDS_OFS_REQ_MASK 8'h62
`define ATDS_OFS_TMO_STAT 8'h63
// Diagnostic status field positions
`define ATDS_DS_SEC_PERR 11
`define ATDS_DS_PRI_PERR 10
`define ATDS_DS_MS1 9
`define ATDS_DS_MS0 8
`define ATDS_DS_ARB_SERR 7
`define ATDS_DS_HS_SW 5
`define ATDS_DS_EXT_ARB 2
`define ATDS_DS_EE_BUSY 1
`define ATDS_DS_ARB_TMO 0
// Diagnostic control field position
`define ATDS_CTL_SERR_EN 7
// Request mask field positions and reset
`define ATDS_RM_AUTO 6
`define ATDS_RM_LINES_HI 3
`define ATDS_MASK_RST 4'h0
// Start timer limit in clocks
`define ATDS_TMO_CLKS 5'h10
`endif

// ---- hdl/atds_arb_diag.v ----
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "atds_map.vh"

module atds_arb_diag (
	// Clock and reset
	input wire ref_clk,
	input wire nrst,
	// Register port
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata_r,
	// Secondary bus arbitration
	input wire [3:0] req_in,
	input wire frame_in,
	output reg [3:0] gnt_r,
	output reg serr_r,
	// Parity error events from bridge masters
	input wire par_err_sec,
	input wire par_err_pri,
	// Pin and block levels shown in status
	input wire mode_select_in0,
	input wire mode_select_in1_clkctl_strap,
	input wire secondary_multifunction_in,
	input wire ext_arb_en,
	input wire eeprom_busy
);

	// Flow in short
	// Grant goes to the lowest unmasked requester
	// Timer counts clocks from grant to frame
	// Sixteenth clock without frame ends the grant
	// Expiry sets the sticky summary flag
	// Expiry sets the flag of the granted line
	// Expiry masks that line if auto masking is on
	// Expiry pulses system error if reporting is on
	// Parity flags only record bridge master errors
	// Arbiter states
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_GNT = 2'h1;
	localparam [1:0] ST_BUSY = 2'h2;

	// Arbiter state and its next value
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	// Cycles since grant without frame
	reg [4:0] cnt_r;
	reg [4:0] cnt_nxt;
	// Grant next value
	reg [3:0] gnt_nxt;
	// Start timeout pulse
	reg tmo_ev;

	// Software register state
	reg ctl_serr_en_r;
	reg ds_sec_perr_r;
	reg ds_pri_perr_r;
	reg ds_arb_serr_r;
	reg ds_arb_tmo_r;
	reg rm_auto_r;
	reg [3:0] rm_mask_r;
	reg [3:0] rm_mask_nxt;
	wire [3:0] tmo_flags;

	// Write decodes
	wire wr_ctl = reg_wr & (reg_addr == `ATDS_OFS_DIAG_CTL);
	wire wr_ds = reg_wr & (reg_addr == `ATDS_OFS_DIAG_STAT);
	wire wr_rm = reg_wr & (reg_addr == `ATDS_OFS_REQ_MASK);
	wire wr_ts = reg_wr & (reg_addr == `ATDS_OFS_TMO_STAT);

	// Write-one clear strobes; a zero bit leaves a flag alone
	wire clr_sec_perr = wr_ds & reg_wdata[`ATDS_DS_SEC_PERR];
	wire clr_pri_perr = wr_ds & reg_wdata[`ATDS_DS_PRI_PERR];
	wire clr_arb_serr = wr_ds & reg_wdata[`ATDS_DS_ARB_SERR];
	wire clr_arb_tmo = wr_ds & reg_wdata[`ATDS_DS_ARB_TMO];
	// Per-line clear strobes for the timeout flags
	wire [3:0] clr_line = {4{wr_ts}} & reg_wdata[`ATDS_RM_LINES_HI:0];

	// Requests the arbiter may see
	wire [3:0] elig = req_in & ~rm_mask_r;
	// Timeout with error reporting enabled
	wire serr_ev = tmo_ev & ctl_serr_en_r;
	// Timer at its last count before expiry
	wire tmo_hit = (cnt_r == (`ATDS_TMO_CLKS - 5'h1));
	// Granted line still asking and unmasked
	wire gnt_live = |(gnt_r & elig);

	// Fixed priority pick, one stage per line
	// Line zero has the highest priority
	// A line wins only if no lower line is eligible
	wire [3:0] pick; // One-hot winner among eligible lines
	wire [3:0] below; // Some lower line is eligible
	genvar p;
	generate
		for (p = 0; p < 4; p = p + 1) begin : g_pick
			if (p == 0) begin : g_first
				// Nothing ranks above line zero
				assign below[p] = 1'b0;
			end else begin : g_rest
				// Carry lower requests upward
				assign below[p] = below[p - 1] | elig[p - 1];
			end
			// Winner bit for this line
			assign pick[p] = elig[p] & ~below[p];
		end
	endgenerate

	// Arbiter next-state logic
	// Idle: grant the winner, clear the timer
	// Granted: wait for frame, drop, or expire
	// Busy: keep the grant while frame stands
	// Timer check comes after the drop check,
	// so a withdrawn line never times out
	// Expiry is a one-clock event
	always @* begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		gnt_nxt = gnt_r;
		tmo_ev = 1'b0;
		case (state_r)
			ST_IDLE: begin
				// Grant only unmasked requesters
				if (|elig) begin
					gnt_nxt = pick;
					cnt_nxt = 5'h0;
					state_nxt = ST_GNT;
				end
			end
			ST_GNT: begin
				if (frame_in) begin
					// Master started; timer stops
					state_nxt = ST_BUSY;
				end else if (!gnt_live) begin
					// Request dropped or masked
					gnt_nxt = 4'h0;
					state_nxt = ST_IDLE;
				end else if (tmo_hit) begin
					// Sixteen clocks without frame
					tmo_ev = 1'b1;
					gnt_nxt = 4'h0;
					state_nxt = ST_IDLE;
				end else begin
					cnt_nxt = cnt_r + 5'h1;
				end
			end
			ST_BUSY: begin
				// Hold grant until frame released
				if (!frame_in) begin
					gnt_nxt = 4'h0;
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				// Unused code, recover to idle
				gnt_nxt = 4'h0;
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Arbiter state register
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			// Start idle
			state_r <= ST_IDLE;
		end else begin
			// Follow the next-state logic
			state_r <= state_nxt;
		end
	end

	// Start timer register
	// Counts clocks since the grant went out
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			// Timer at zero
			cnt_r <= 5'h0;
		end else begin
			// Restarted on grant, held once frame seen
			cnt_r <= cnt_nxt;
		end
	end

	// Grant register
	// Straight from a flop, so no decode glitches
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			// No line granted
			gnt_r <= 4'h0;
		end else begin
			// One-hot or zero
			gnt_r <= gnt_nxt;
		end
	end

	// System error pulse
	// One clock per reported expiry
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			// Quiet after reset
			serr_r <= 1'b0;
		end else begin
			// Follows the gated expiry event
			serr_r <= serr_ev;
		end
	end

	// Request mask next value; auto set wins over write
	// Software write lands first, expiry ORs on top
	// A line cannot dodge masking by a racing write
	// Software clears an auto mask by writing zero
	always @* begin
		rm_mask_nxt = rm_mask_r;
		if (wr_rm)
			rm_mask_nxt = reg_wdata[`ATDS_RM_LINES_HI:0];
		if (tmo_ev & rm_auto_r)
			rm_mask_nxt = rm_mask_nxt | gnt_r;
	end

	// Error reporting enable in the control word
	// Off after reset, so expiry stays silent
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			// Reporting disabled
			ctl_serr_en_r <= 1'b0;
		end else if (wr_ctl) begin
			// Only the enable bit of the word is kept
			ctl_serr_en_r <= reg_wdata[`ATDS_CTL_SERR_EN];
		end
	end

	// Automatic masking enable
	// Off after reset, so no line masks itself
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			// Automatic masking off
			rm_auto_r <= 1'b0;
		end else if (wr_rm) begin
			// Software sets or clears it
			rm_auto_r <= reg_wdata[`ATDS_RM_AUTO];
		end
	end

	// Request line masks
	// Reset leaves every line usable
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			// All lines usable
			rm_mask_r <= `ATDS_MASK_RST;
		end else begin
			// Write and automatic masking merged
			rm_mask_r <= rm_mask_nxt;
		end
	end

	// Secondary side parity error flag
	// An event in the clear cycle keeps it set
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			// Clear after reset
			ds_sec_perr_r <= 1'b0;
		end else if (par_err_sec) begin
			// Event sets, even against a clear
			ds_sec_perr_r <= 1'b1;
		end else if (clr_sec_perr) begin
			// Write one clears
			ds_sec_perr_r <= 1'b0;
		end
	end

	// Primary side parity error flag
	// An event in the clear cycle keeps it set
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			// Clear after reset
			ds_pri_perr_r <= 1'b0;
		end else if (par_err_pri) begin
			// Event sets, even against a clear
			ds_pri_perr_r <= 1'b1;
		end else if (clr_pri_perr) begin
			// Write one clears
			ds_pri_perr_r <= 1'b0;
		end
	end

	// System error from arbiter timer
	// Only reported expiries reach this flag
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			// Clear after reset
			ds_arb_serr_r <= 1'b0;
		end else if (serr_ev) begin
			// Event sets, even against a clear
			ds_arb_serr_r <= 1'b1;
		end else if (clr_arb_serr) begin
			// Write one clears
			ds_arb_serr_r <= 1'b0;
		end
	end

	// Any start timeout, reported or not
	// Summary of all lines in one flag
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			// Clear after reset
			ds_arb_tmo_r <= 1'b0;
		end else if (tmo_ev) begin
			// Event sets, even against a clear
			ds_arb_tmo_r <= 1'b1;
		end else if (clr_arb_tmo) begin
			// Write one clears
			ds_arb_tmo_r <= 1'b0;
		end
	end

	// Per-line timeout flags
	// The expiring grant names the line to flag
	// Set wins over a clear in the same clock
	// Upper reserved bits have no flops at all
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_tmo
			reg flag_r;
			// Set by this line's timeout, write one clears
			always @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					flag_r <= 1'b0;
				end else begin
					// Event for this line sets, write one clears
					flag_r <= (tmo_ev & gnt_r[g]) | (flag_r & ~clr_line[g]);
				end
			end
			assign tmo_flags[g] = flag_r;
		end
	endgenerate

	// Read images; reserved bits are zero
	// Pin levels go out live, as sampled now
	// Writes never reach read-only fields
	wire [15:0] img_ctl = {8'h00, ctl_serr_en_r, 7'h00};
	wire [15:0] img_ds = {4'h0,
		ds_sec_perr_r,
		ds_pri_perr_r,
		mode_select_in1_clkctl_strap,
		mode_select_in0,
		ds_arb_serr_r,
		1'b0,
		secondary_multifunction_in,
		2'h0,
		ext_arb_en,
		eeprom_busy,
		ds_arb_tmo_r};
	wire [15:0] img_rm = {8'h00, 1'b0, rm_auto_r, 2'h0, rm_mask_r};
	wire [15:0] img_ts = {12'h000, tmo_flags};

	// Read data, one cycle after the strobe
	// Zero outside the answer cycle
	// Keeps stale data off the bus
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata_r <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`ATDS_OFS_DIAG_CTL: reg_rdata_r <= img_ctl;
				`ATDS_OFS_DIAG_STAT: reg_rdata_r <= img_ds;
				`ATDS_OFS_REQ_MASK: reg_rdata_r <= img_rm;
				`ATDS_OFS_TMO_STAT: reg_rdata_r <= img_ts;
				// Unmapped reads return zero
				default: reg_rdata_r <= 16'h0000;
			endcase
		end else begin
			reg_rdata_r <= 16'h0000;
		end
	end

endmodule // atds_arb_diag
`default_nettype wire

// ---- hdl/atds_unused_guard.v ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- testbench/atds_checker_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module atds_checker (
	// Clock and reset
	input wire ref_clk,
	input wire nrst,
	// Bus and arbiter
	input wire [7:0] reg_addr,
	input wire reg_rd,
	input wire [15:0] reg_rdata_r,
	input wire [3:0] gnt_r,
	input wire frame_in,
	input wire serr_r,
	// Mirrored pins
	input wire mode_select_in0,
	input wire mode_select_in1_clkctl_strap
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	reg rd_r; // Read seen last edge
	reg [7:0] ad_r; // Its address
	// Remember the read for the answer cycle
	always @(posedge ref_clk) begin
		rd_r <= reg_rd;
		ad_r <= reg_addr;
	end
	property p_rsvd; rd_r && ad_r == 8'h5E |-> reg_rdata_r[15:12] == 4'h0 && !reg_rdata_r[6]; endproperty
	a_rsvd: assert property (p_rsvd) else $error("diag reserved bit set");
	property p_ms; rd_r && ad_r == 8'h5E |-> reg_rdata_r[9:8] == {$past(mode_select_in1_clkctl_strap), $past(mode_select_in0)}; endproperty
	a_ms: assert property (p_ms) else $error("mode pins not mirrored");
	property p_rsvt; rd_r && ad_r == 8'h63 |-> reg_rdata_r[7:4] == 4'h0; endproperty
	a_rsvt: assert property (p_rsvt) else $error("timeout reserved bit set");
	property p_rsvm; rd_r && ad_r == 8'h62 |-> !reg_rdata_r[7] && reg_rdata_r[5:4] == 2'b00; endproperty
	a_rsvm: assert property (p_rsvm) else $error("mask reserved bit set");
	property p_tmo; $rose(|gnt_r) |-> ##[1:16] (gnt_r == 4'h0 || frame_in); endproperty
	a_tmo: assert property (p_tmo) else $error("grant outlived start timer");
	property p_serr; serr_r |-> $fell(|gnt_r) ##1 !serr_r; endproperty
	a_serr: assert property (p_serr) else $error("error pulse without timeout");
	property p_gap; gnt_r != 4'h0 && $past(gnt_r) != 4'h0 |-> gnt_r == $past(gnt_r); endproperty
	a_gap: assert property (p_gap) else $error("grant moved without an idle cycle");
	property p_one; $onehot0(gnt_r); endproperty
	a_one: assert property (p_one) else $error("grant not one-hot");
endmodule // atds_checker
bind atds_arb_diag atds_checker chk_u (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_rd(reg_rd),
	.reg_rdata_r(reg_rdata_r), .gnt_r(gnt_r), .frame_in(frame_in), .serr_r(serr_r),
	.mode_select_in0(mode_select_in0), .mode_select_in1_clkctl_strap(mode_select_in1_clkctl_strap));
`default_nettype wire

// ---- testbench/atds_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module atds_master_model (
	// Clock and reset
	input wire ref_clk,
	input wire nrst,
	// Lines wanting the bus, lines that never start
	input wire [3:0] want,
	input wire [3:0] stall,
	// Bus side
	input wire [3:0] gnt,
	output wire [3:0] req,
	output reg frame_r
);
	reg [3:0] gnt_r; // Grant seen last edge
	assign req = want;
	// One-cycle start on a fresh grant unless stalled
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			gnt_r <= 4'h0;
			frame_r <= 1'b0;
		end else begin
			gnt_r <= gnt;
			frame_r <= |(gnt & ~gnt_r & ~stall);
		end
	end
endmodule // atds_master_model
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
	reg ref_clk = 1'b0;
	reg nrst = 1'b0;
	reg [7:0] a = 8'h00;
	reg [15:0] wd = 16'h0000;
	reg wr_s = 1'b0;
	reg rd_s = 1'b0;
	reg [3:0] want = 4'h0;
	reg [3:0] stall = 4'h0;
	reg pe_s = 1'b0;
	reg pe_p = 1'b0;
	reg [4:0] pins = 5'h15; // Strap, mode, switch, arbiter, busy
	wire [15:0] rdata;
	wire [3:0] req;
	wire [3:0] gnt;
	wire frame;
	wire serr;
	wire [15:0] base = {6'h00, pins[4:3], 2'b00, pins[2], 2'b00, pins[1:0], 1'b0};
	integer n_fail = 0;
	integer samples_checked = 0;
	integer cyc = 0;
	integer n_serr = 0; // System error pulses seen
	always #25 ref_clk = ~ref_clk;
	atds_arb_diag dut_u (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(a), .reg_wdata(wd), .reg_wr(wr_s),
		.reg_rd(rd_s), .reg_rdata_r(rdata), .req_in(req), .frame_in(frame), .gnt_r(gnt), .serr_r(serr),
		.par_err_sec(pe_s), .par_err_pri(pe_p), .mode_select_in0(pins[3]), .mode_select_in1_clkctl_strap(pins[4]),
		.secondary_multifunction_in(pins[2]), .ext_arb_en(pins[1]), .eeprom_busy(pins[0]));
	atds_master_model mst_u (.ref_clk(ref_clk), .nrst(nrst), .want(want), .stall(stall), .gnt(gnt), .req(req),
		.frame_r(frame));
	task chk(input [15:0] s, input [15:0] e); begin
		samples_checked = samples_checked + 1;
		if (s !== e) begin
			n_fail = n_fail + 1;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	end endtask
	task wr(input [7:0] ad, input [15:0] d); begin
		a <= ad;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge ref_clk);
		wr_s <= 1'b0;
		@(posedge ref_clk);
	end endtask
	task rd(input [7:0] ad, input [15:0] e); begin
		a <= ad;
		rd_s <= 1'b1;
		@(posedge ref_clk);
		rd_s <= 1'b0;
		@(negedge ref_clk);
		chk(rdata, e);
		@(posedge ref_clk);
	end endtask
	task close_out; begin
		$display("mismatches %0d of %0d checks", n_fail, samples_checked);
		if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	end endtask
	// Count system error pulses
	always @(posedge ref_clk) begin
		if (serr === 1'b1)
			n_serr <= n_serr + 1;
	end
	// Cut a hang short
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail = n_fail + 1;
			close_out;
		end
	end
	initial begin
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		rd(8'h62, 16'h0000);
		rd(8'h63, 16'h0000);
		rd(8'h5E, base);
		pins <= 5'h0A;
		wr(8'h5E, 16'hF37E);
		rd(8'h5E, base);
		wr(8'h62, 16'h00FF);
		rd(8'h62, 16'h004F);
		rd(8'h70, 16'h0000);
		want <= 4'hF;
		stall <= 4'h1;
		repeat (20) @(posedge ref_clk);
		chk({12'h000, gnt}, 16'h0000);
		wr(8'h5C, 16'h0080);
		wr(8'h62, 16'h004E);
		repeat (30) @(posedge ref_clk);
		rd(8'h63, 16'h0001);
		rd(8'h62, 16'h004F);
		rd(8'h5E, base | 16'h0081);
		chk(n_serr[15:0], 16'h0001);
		wr(8'h63, 16'h0000);
		rd(8'h63, 16'h0001);
		wr(8'h63, 16'h0001);
		rd(8'h63, 16'h0000);
		wr(8'h5E, 16'h0081);
		rd(8'h5E, base);
		wr(8'h5C, 16'h0000);
		stall <= 4'h2;
		wr(8'h62, 16'h000D);
		repeat (30) @(posedge ref_clk);
		rd(8'h62, 16'h000D);
		rd(8'h5E, base | 16'h0001);
		chk(n_serr[15:0], 16'h0001);
		want <= 4'h4;
		stall <= 4'h0;
		wr(8'h63, 16'h000F);
		wr(8'h5E, 16'h0001);
		wr(8'h62, 16'h0000);
		repeat (40) @(posedge ref_clk);
		rd(8'h63, 16'h0000);
		want <= 4'h0;
		pe_s <= 1'b1;
		pe_p <= 1'b1;
		@(posedge ref_clk);
		pe_s <= 1'b0;
		pe_p <= 1'b0;
		rd(8'h5E, base | 16'h0C00);
		wr(8'h5E, 16'h0800);
		rd(8'h5E, base | 16'h0400);
		wr(8'h5E, 16'h0400);
		rd(8'h5E, base);
		close_out;
	end
endmodule // testbench
`default_nettype wire
